// ==== hw/ufp_pkg.sv ====
// Package of constants and types shared by the fire pulse generator files.
package ufp_pkg;

   // ---------------------------------------------------------------
   // Register map (register index on the write port)
   // ---------------------------------------------------------------
   localparam logic [2:0] REG_BURST_TIMING_CONFIG = 3'h0;
   localparam logic [2:0] REG_BURST_OUTPUT_CONFIG = 3'h5;

   // burst_output_config fields.
   localparam int PHASE_LSB      = 0;
   localparam int PHASE_W        = 16;
   localparam int REPEAT_LSB     = 16;
   localparam int REPEAT_W       = 3;
   localparam int DITHER_DIS_BIT = 19;
   localparam int HZ_A_BIT       = 21;
   localparam int HZ_B_BIT       = 22;
   localparam int INV_B_BIT      = 23;

   // burst_timing_config fields.
   localparam int COUNT_LSB = 0;
   localparam int COUNT_W   = 4;
   localparam int DIV_LSB   = 4;
   localparam int DIV_W     = 4;

   // Reset values.
   localparam logic [23:0] RST_OUTPUT_CONFIG = 24'h000000;
   localparam logic [23:0] RST_TIMING_CONFIG = 24'h000000;
   localparam logic [7:0]  RST_LFSR          = 8'hA5;

   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_BEGIN_CYCLE = 8'h01;
   localparam logic [7:0] OPC_INIT        = 8'h70;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int QUIET_TIME_NS = 5000;
   localparam int QUIET_CYCLES  = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUIET_W       = 7;
   localparam logic [QUIET_W-1:0] QUIET_LAST = QUIET_W'(QUIET_CYCLES - 1);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_DITHER = 2'b01,
      ST_PULSE  = 2'b10,
      ST_ECHO   = 2'b11
   } ufp_state_e;

   typedef struct packed {
      logic        en;
      logic [2:0]  addr;
      logic [23:0] data;
   } ufp_reg_wr_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } ufp_cmd_s;

   typedef struct packed {
      logic drive_out_a;
      logic drive_out_a_oe_n;
      logic drive_out_b;
      logic drive_out_b_oe_n;
   } ufp_drive_s;

endpackage

// ==== hw/ufp_rate_gen.sv ====
// Pulse clock rate generator: doubled base rate divided by setting plus one.
`timescale 1ns/1ns
module ufp_rate_gen
   import ufp_pkg::*;
(
   input  wire logic         clock, // Predivided fast clock.
   input  wire logic         rst,   // Asynchronous reset, active high.
   input  wire logic         run,   // Count while high, clear while low.
   input  wire logic [3:0]   div,   // Burst clock divider setting.
   output logic              tick   // One pulse clock period has elapsed.
);
   import ufp_pkg::*;

   typedef struct packed {
      logic [4:0] acc;
   } ufp_rate_s;

   ufp_rate_s r;
   ufp_rate_s next_r;
   logic [4:0] modulus;
   logic [4:0] sum;

   // A zero setting is forbidden; it is treated as one so the block never stalls.
   assign modulus = (div == 4'h0) ? 5'h02 : {1'b0, div} + 5'h01;
   assign sum     = r.acc + 5'h02;
   assign tick    = run && (sum >= modulus);

   // Adding two per cycle is the doubling; odd ratios give edges on alternate
   // cycle boundaries, which is the closest a single clock domain can get.
   always_comb begin
      next_r = r;
      if (!run) begin
         next_r.acc = 5'h00;
      end else if (sum >= modulus) begin
         next_r.acc = sum - modulus;
      end else begin
         next_r.acc = sum;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   property p_div_one_every_cycle;
      @(posedge clock) disable iff (rst)
      (run && $past(run) && div == 4'h1) |-> tick;
   endproperty
   a_div_one_every_cycle: assert property (p_div_one_every_cycle) else $error("ratio 2 must tick every cycle");

   property p_div_fifteen_spacing;
      @(posedge clock) disable iff (rst)
      (run && tick && div == 4'hF) ##1 (run && div == 4'hF)[*7] |-> !tick;
   endproperty
   a_div_fifteen_spacing: assert property (p_div_fifteen_spacing) else $error("ratio 16 ticked too early");

endmodule

// ==== hw/ufp_fire_gen.sv ====
// Ultrasonic fire pulse generator: burst sequencing, phases, drivers, repetition.
`timescale 1ns/1ns
module ufp_fire_gen
   import ufp_pkg::*;
(
   input  wire logic              clock,   // Fast clock after its predivider.
   input  wire logic              rst,     // Asynchronous reset, active high.
   input  wire ufp_pkg::ufp_reg_wr_s reg_wr,  // Register write strobe, index, data.
   input  wire ufp_pkg::ufp_cmd_s    cmd,     // Opcode strobe and code.
   input  wire logic              echo_in, // Received echo sequence.
   output ufp_pkg::ufp_drive_s    drive,   // Pulse outputs and their enables.
   output logic                   busy     // Burst or repetition in progress.
);
   import ufp_pkg::*;

   typedef struct packed {
      ufp_state_e          state;
      logic [23:0]         out_cfg;
      logic [23:0]         tim_cfg;
      logic [3:0]          pulse_idx;
      logic                half;
      logic                level;
      logic [2:0]          rep_left;
      logic [QUIET_W-1:0]  quiet_cnt;
      logic [3:0]          echo_cnt;
      logic                echo_prev;
      logic [7:0]          lfsr;
      logic [1:0]          dith_cnt;
   } ufp_fire_s;

   ufp_fire_s r;
   ufp_fire_s next_r;

   logic [15:0] phase;
   logic [2:0]  repeat_cfg;
   logic        dither_dis;
   logic        hz_a;
   logic        hz_b;
   logic        inv_b;
   logic [3:0]  pulse_cnt;
   logic [3:0]  div_cfg;
   logic        tick;
   logic        start;
   logic        abort;
   logic        echo_gate;
   logic        raw;

   assign phase      = r.out_cfg[PHASE_LSB +: PHASE_W];
   assign repeat_cfg = r.out_cfg[REPEAT_LSB +: REPEAT_W];
   assign dither_dis = r.out_cfg[DITHER_DIS_BIT];
   assign hz_a       = r.out_cfg[HZ_A_BIT];
   assign hz_b       = r.out_cfg[HZ_B_BIT];
   assign inv_b      = r.out_cfg[INV_B_BIT];
   assign pulse_cnt  = r.tim_cfg[COUNT_LSB +: COUNT_W];
   assign div_cfg    = r.tim_cfg[DIV_LSB +: DIV_W];

   assign start = cmd.valid && (cmd.code == OPC_BEGIN_CYCLE);
   assign abort = cmd.valid && (cmd.code == OPC_INIT);

   // ---------------------------------------------------------------
   // Pulse clock
   // ---------------------------------------------------------------
   ufp_rate_gen u_rate (
      .clock (clock),
      .rst   (rst),
      .run   (r.state == ST_PULSE),
      .div   (div_cfg),
      .tick  (tick)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Echo pulses beyond the programmed count are blocked from the drivers.
   assign echo_gate = (r.echo_cnt < pulse_cnt);

   always_comb begin
      next_r           = r;
      next_r.echo_prev = echo_in;
      next_r.lfsr      = {r.lfsr[6:0], r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3]};
      if (reg_wr.en && reg_wr.addr == REG_BURST_OUTPUT_CONFIG) begin
         next_r.out_cfg = reg_wr.data;
      end
      if (reg_wr.en && reg_wr.addr == REG_BURST_TIMING_CONFIG) begin
         next_r.tim_cfg = reg_wr.data;
      end
      case (r.state)
         ST_IDLE: begin
            next_r.level = 1'b0;
            // A zero pulse count leaves the generator switched off.
            if (start && pulse_cnt != 4'h0) begin
               next_r.pulse_idx = 4'h0;
               next_r.half      = 1'b0;
               next_r.rep_left  = repeat_cfg;
               if (!dither_dis) begin
                  next_r.state    = ST_DITHER;
                  next_r.dith_cnt = r.lfsr[1:0];
               end else begin
                  next_r.state = ST_PULSE;
                  next_r.level = phase[0];
               end
            end
         end
         ST_DITHER: begin
            // The random delay moves the burst against the measuring clock
            // so that averaged results hit different quantisation steps.
            if (r.dith_cnt == 2'h0) begin
               next_r.state = ST_PULSE;
               next_r.level = phase[0];
            end else begin
               next_r.dith_cnt = r.dith_cnt - 2'h1;
            end
         end
         ST_PULSE: begin
            if (tick) begin
               if (!r.half) begin
                  next_r.half  = 1'b1;
                  next_r.level = ~phase[r.pulse_idx];
               end else if (r.pulse_idx + 4'h1 == pulse_cnt) begin
                  next_r.level     = 1'b0;
                  next_r.quiet_cnt = '0;
                  next_r.echo_cnt  = 4'h0;
                  next_r.state     = (r.rep_left != 3'h0) ? ST_ECHO : ST_IDLE;
               end else begin
                  next_r.half      = 1'b0;
                  next_r.pulse_idx = r.pulse_idx + 4'h1;
                  next_r.level     = phase[r.pulse_idx + 4'h1];
               end
            end
         end
         ST_ECHO: begin
            if (r.echo_prev && !echo_in && echo_gate) begin
               next_r.echo_cnt = r.echo_cnt + 4'h1;
            end
            // Quiet time only counts once an echo has arrived, since the
            // flight itself is usually longer than the quiet window.
            if (echo_in || r.echo_cnt == 4'h0) begin
               next_r.quiet_cnt = '0;
            end else if (r.quiet_cnt == QUIET_LAST) begin
               next_r.quiet_cnt = '0;
               next_r.echo_cnt  = 4'h0;
               next_r.rep_left  = r.rep_left - 3'h1;
               if (r.rep_left == 3'h1) begin
                  next_r.state = ST_IDLE;
               end
            end else begin
               next_r.quiet_cnt = r.quiet_cnt + QUIET_W'(1);
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
      // Init is the only way out of a repetition whose echo never comes.
      if (abort) begin
         next_r.state = ST_IDLE;
         next_r.level = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r           <= '0;
         r.state     <= ST_IDLE;
         r.out_cfg   <= RST_OUTPUT_CONFIG;
         r.tim_cfg   <= RST_TIMING_CONFIG;
         r.lfsr      <= RST_LFSR;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Output drivers
   // ---------------------------------------------------------------
   // The echo path is combinational on purpose: re-emission must not wait a clock.
   assign raw                    = (r.state == ST_ECHO) ? (echo_in && echo_gate) : r.level;
   assign drive.drive_out_a      = raw;
   assign drive.drive_out_b      = raw ^ inv_b;
   assign drive.drive_out_a_oe_n = hz_a;
   assign drive.drive_out_b_oe_n = hz_b;
   assign busy                   = (r.state != ST_IDLE);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_zero_count_off;
      @(posedge clock) disable iff (rst)
      (r.state == ST_IDLE && start && pulse_cnt == 4'h0) |=> (r.state == ST_IDLE);
   endproperty
   a_zero_count_off: assert property (p_zero_count_off) else $error("zero count must not start");

   property p_start_no_dither;
      @(posedge clock) disable iff (rst)
      (r.state == ST_IDLE && start && !abort && pulse_cnt != 4'h0 && dither_dis) |=>
         (r.state == ST_PULSE && r.level == $past(phase[0]));
   endproperty
   a_start_no_dither: assert property (p_start_no_dither) else $error("burst did not start on opcode");

   property p_dither_bounded;
      @(posedge clock) disable iff (rst)
      (r.state == ST_IDLE && start && !abort && pulse_cnt != 4'h0 && !dither_dis) |=>
         (r.state == ST_DITHER) ##[1:4] (r.state == ST_PULSE || abort);
   endproperty
   a_dither_bounded: assert property (p_dither_bounded) else $error("dither shift out of range");

   property p_idle_low;
      @(posedge clock) disable iff (rst)
      (r.state == ST_IDLE) |-> (!drive.drive_out_a && drive.drive_out_b == inv_b);
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("outputs not at rest level");

   property p_drv_cfg;
      @(posedge clock) disable iff (rst)
      (reg_wr.en && reg_wr.addr == REG_BURST_OUTPUT_CONFIG) |=>
         ((drive.drive_out_a ^ drive.drive_out_b) == $past(reg_wr.data[INV_B_BIT])
          && drive.drive_out_a_oe_n == $past(reg_wr.data[HZ_A_BIT])
          && drive.drive_out_b_oe_n == $past(reg_wr.data[HZ_B_BIT]));
   endproperty
   a_drv_cfg: assert property (p_drv_cfg) else $error("output B inversion wrong");

   property p_half_stable;
      @(posedge clock) disable iff (rst)
      (r.state == ST_PULSE && !tick && !abort) |=> $stable(r.level) && $stable(r.half);
   endproperty
   a_half_stable: assert property (p_half_stable) else $error("pulse level moved without pulse clock");

   property p_second_half;
      @(posedge clock) disable iff (rst)
      (r.state == ST_PULSE && tick && !r.half && !abort) |=>
         (r.half && r.level == !$past(phase[r.pulse_idx]));
   endproperty
   a_second_half: assert property (p_second_half) else $error("second half has wrong level");

   property p_echo_pass;
      @(posedge clock) disable iff (rst)
      (r.state == ST_ECHO && echo_gate) |-> (drive.drive_out_a == echo_in);
   endproperty
   a_echo_pass: assert property (p_echo_pass) else $error("echo not forwarded at once");

   property p_echo_block;
      @(posedge clock) disable iff (rst)
      (r.state == ST_ECHO && !echo_gate) |-> !drive.drive_out_a;
   endproperty
   a_echo_block: assert property (p_echo_block) else $error("extra echo pulse forwarded");

   property p_quiet_end;
      @(posedge clock) disable iff (rst)
      (r.state == ST_ECHO && r.quiet_cnt == QUIET_LAST && !echo_in && r.echo_cnt != 4'h0 && !abort) |=>
         (r.rep_left == $past(r.rep_left) - 3'h1 && r.quiet_cnt == '0);
   endproperty
   a_quiet_end: assert property (p_quiet_end) else $error("quiet time did not end repetition");

   property p_rep_step;
      @(posedge clock) disable iff (rst)
      (r.state == ST_ECHO && $changed(r.rep_left)) |-> (r.rep_left == $past(r.rep_left) - 3'h1);
   endproperty
   a_rep_step: assert property (p_rep_step) else $error("repeat count jumped");

   property p_rep_load;
      @(posedge clock) disable iff (rst)
      (r.state == ST_IDLE && start && !abort && pulse_cnt != 4'h0) |=>
         (r.rep_left == $past(repeat_cfg));
   endproperty
   a_rep_load: assert property (p_rep_load) else $error("repeat count not loaded at start");

   property p_pulse_end;
      @(posedge clock) disable iff (rst)
      (r.state == ST_PULSE && tick && r.half && r.pulse_idx + 4'h1 == pulse_cnt && !abort) |=>
         (!r.level && (r.state == ST_IDLE || r.state == ST_ECHO));
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("burst did not end after last pulse");

   property p_abort_idle;
      @(posedge clock) disable iff (rst)
      abort |=> (r.state == ST_IDLE && !r.level);
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("init did not return to rest");

   c_burst_done: cover property (@(posedge clock) disable iff (rst)
      (r.state == ST_PULSE) ##1 (r.state == ST_IDLE));
   c_echo_mode: cover property (@(posedge clock) disable iff (rst)
      (r.state == ST_PULSE) ##1 (r.state == ST_ECHO));
   c_dither: cover property (@(posedge clock) disable iff (rst)
      (r.state == ST_DITHER) ##1 (r.state == ST_PULSE));
   c_rep_over: cover property (@(posedge clock) disable iff (rst)
      (r.state == ST_ECHO) ##1 (r.state == ST_IDLE));
   c_abort: cover property (@(posedge clock) disable iff (rst)
      (abort && r.state != ST_IDLE) ##1 (r.state == ST_IDLE));

endmodule

// ==== verification/ufp_xdcr_model.sv ====
// Transducer model: returns a received echo train to the generator on request.
`timescale 1ns/1ns
module ufp_xdcr_model
   import ufp_pkg::*;
(
   input  wire logic                clock, // Pulse base clock.
   input  wire ufp_pkg::ufp_drive_s drive, // Fire outputs arriving at the transducer.
   output logic                     echo   // Received echo towards the generator.
);
   // -----------------------------------------------------------
   // Echo train
   // -----------------------------------------------------------
   // The receiver line rests low between trains, so no stale level is left on it.
   initial echo = 1'b0;

   // Counts cycles in which output A drives high; the bench compares it across a burst.
   int hi_cycles = 0;
   always @(posedge clock) begin
      if (drive.drive_out_a && !drive.drive_out_a_oe_n) begin
         hi_cycles <= hi_cycles + 1;
      end
   end

   // Trains stay under a microsecond long so all repetitions fit one measuring range.
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         echo = 1'b1;
         repeat (3) @(negedge clock);
         echo = 1'b0;
         repeat (1) @(negedge clock);
      end
   endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench of the fire pulse generator.
`timescale 1ns/1ns
module testbench;
   import ufp_pkg::*;
   logic        clock     = 1'b0;
   logic        rst       = 1'b1;
   ufp_reg_wr_s reg_wr    = '0;
   ufp_cmd_s    cmd       = '0;
   logic        echo_in;
   ufp_drive_s  drive;
   logic        busy;
   logic [23:0] ocfg      = 24'h000000;
   int          err_total = 0;
   int          n_checks  = 0;

   // The pulse base never changes during the run, so both flights of a pair share one calibration.
   always #25 clock = ~clock;

   ufp_fire_gen i_ufp_fire_gen (
      .clock   (clock),
      .rst     (rst),
      .reg_wr  (reg_wr),
      .cmd     (cmd),
      .echo_in (echo_in),
      .drive   (drive),
      .busy    (busy)
   );

   ufp_xdcr_model i_ufp_xdcr_model (
      .clock (clock),
      .drive (drive),
      .echo  (echo_in)
   );

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_pins(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_count(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   // Expected pins from the level of output A and the mirrored output config.
   function automatic logic [4:0] exp_pins(input logic a, input logic b);
      return {a, ocfg[HZ_A_BIT], a ^ ocfg[INV_B_BIT], ocfg[HZ_B_BIT], b};
   endfunction

   task automatic wr(input logic [2:0] addr, input logic [23:0] data);
      @(negedge clock);
      reg_wr = {1'b1, addr, data};
      @(negedge clock);
      reg_wr.en = 1'b0;
      if (addr == REG_BURST_OUTPUT_CONFIG)
         ocfg = data;
   endtask

   // Returns at the falling edge just after the opcode was taken.
   task automatic start(input logic [7:0] code);
      @(negedge clock);
      cmd = {1'b1, code};
      @(negedge clock);
      cmd.valid = 1'b0;
   endtask

   task automatic wait_idle(output int n, input int lim);
      n = 0;
      while (busy !== 1'b0) begin
         @(negedge clock);
         n++;
         if (n > lim) begin
            err_total++;
            end_of_test();
         end
      end
   endtask

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   // Dither off, so every half pulse is one pulse clock period long from the first cycle.
   task automatic t_burst(input int cnt, input logic [15:0] ph, input logic [3:0] dv, input logic [23:0] oc);
      int h;
      int f0;
      h = (dv + 1) / 2;
      wr(REG_BURST_TIMING_CONFIG, {16'h0000, dv, 4'(cnt)});
      wr(REG_BURST_OUTPUT_CONFIG, oc | 24'h080000 | 24'(ph));
      f0 = i_ufp_xdcr_model.hi_cycles;
      start(OPC_BEGIN_CYCLE);
      for (int i = 0; i < 2 * cnt * h; i++) begin
         chk_pins({drive, busy}, exp_pins(ph[i / (2 * h)] ^ ((i % (2 * h)) >= h), 1'b1));
         @(negedge clock);
      end
      chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
      chk_count(i_ufp_xdcr_model.hi_cycles - f0, cnt * h, cnt * h);
   endtask

   task automatic t_dither();
      int n;
      wr(REG_BURST_TIMING_CONFIG, 24'h000012);
      wr(REG_BURST_OUTPUT_CONFIG, 24'h000003);
      for (int k = 0; k < 3; k++) begin
         start(OPC_BEGIN_CYCLE);
         wait_idle(n, 40);
         chk_count(n, 5, 8);
      end
      wr(REG_BURST_OUTPUT_CONFIG, 24'h080003);
      start(OPC_BEGIN_CYCLE);
      wait_idle(n, 40);
      chk_count(n, 4, 4);
   endtask

   task automatic t_zero();
      wr(REG_BURST_TIMING_CONFIG, 24'h000010);
      start(OPC_BEGIN_CYCLE);
      repeat (3) begin
         chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
         @(negedge clock);
      end
   endtask

   task automatic t_outputs();
      logic [23:0] v[4] = '{24'h800000, 24'h400000, 24'h200000, 24'hE00000};
      foreach (v[i]) begin
         wr(REG_BURST_OUTPUT_CONFIG, v[i]);
         @(negedge clock);
         chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
      end
      wr(3'h3, 24'h000000);
      @(negedge clock);
      chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
   endtask

   // Two pulses fired, then three echoes offered: only two may pass, with no clocked delay.
   task automatic t_echo(input logic [2:0] r);
      int falls;
      int since;
      int n;
      logic prev;
      falls = 0;
      since = 0;
      prev = 1'b0;
      wr(REG_BURST_TIMING_CONFIG, 24'h000012);
      wr(REG_BURST_OUTPUT_CONFIG, 24'h880000 | {5'h00, r, 16'h0000});
      start(OPC_BEGIN_CYCLE);
      repeat (4) @(negedge clock);
      chk_pins({4'h0, busy}, 5'h01);
      fork
         i_ufp_xdcr_model.send(3);
         for (int i = 0; i < 16; i++) begin
            @(negedge clock);
            #10;
            chk_pins({drive, busy}, exp_pins(echo_in & (falls < 2), 1'b1));
            since++;
            if (prev && !echo_in) begin
               falls++;
               since = 0;
            end
            prev = echo_in;
         end
      join
      if (r == 3'h1) begin
         wait_idle(n, 120);
         chk_count(n + since, 100, 102);
      end else begin
         repeat (105) @(negedge clock);
         chk_pins({4'h0, busy}, 5'h01);
         start(OPC_INIT);
         chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
      end
   endtask

   task automatic t_abort();
      wr(REG_BURST_TIMING_CONFIG, 24'h00001F);
      start(OPC_BEGIN_CYCLE);
      repeat (3) @(negedge clock);
      start(OPC_INIT);
      chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
   endtask

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (3) @(negedge clock);
      rst = 1'b0;
      chk_pins({drive, busy}, exp_pins(1'b0, 1'b0));
      t_burst(3, 16'h0005, 4'h1, 24'h000000);
      t_burst(2, 16'h0002, 4'h3, 24'h000000);
      t_burst(15, 16'h9C3A, 4'h1, 24'h800000);
      t_burst(1, 16'h0001, 4'hF, 24'h000000);
      t_zero();
      t_outputs();
      t_dither();
      t_echo(3'h1);
      t_echo(3'h2);
      t_abort();
      end_of_test();
   end
endmodule
